// ===== inc/dcb_regs.svh
`ifndef DCB_REGS_SVH
`define DCB_REGS_SVH
`define DCB_CNT_W 16
`define DCB_BYTE_W 8
`define DCB_CNT_RST 16'h0000
`define DCB_BYTE_LO 0
`define DCB_BYTE_HI 8
`endif

// ===== inc/dcb_pkg.sv
package dcb_pkg;
    typedef logic [15:0] dcb_count_t;
    typedef struct packed {
        logic first_low_byte_gate_n;
        logic first_high_byte_gate_n;
        logic second_low_byte_gate_n;
        logic second_high_byte_gate_n;
    } dcb_gates_s;
    typedef struct packed {
        dcb_count_t second;
        dcb_count_t first;
    } dcb_snap_s;
endpackage

// ===== src/dcb_edge_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser followed by a rising-edge detector on the second stage
module dcb_edge_sync (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pin and result
    input wire logic pin,
    output logic level,
    output logic rise
);
    logic meta_r;
    logic sync_r;
    logic prev_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    assign level = sync_r;
    assign rise = sync_r & ~prev_r;
endmodule

// ===== src/dcb_dual_counter.sv
`timescale 1ns/1ns
`include "dcb_regs.svh"
// What this block does
// - the first counter steps by one on each rising edge of its count clock.
// - the second counter steps by one on each rising edge of its own count clock when enabled.
// - the second counter counts only while its enable is low and ignores edges while high.
// - a low shared clear zeroes both counters at once without waiting for a count edge.
// - each rising edge of the register clock copies both counts into the snapshot.
// - the terminal count output is low while the first counter is all ones, else high.
// - the first low byte gate puts the stored first low byte on the bus.
// - the first high byte gate puts the stored first high byte on the bus.
// - the second low byte gate puts the stored second low byte on the bus.
// - the second high byte gate puts the stored second high byte on the bus.
// - bus line 0 carries the least significant bit and line 7 the most significant.
// - each counter is CNT_W bits wide (sixteen by default) and counts up in plain binary.
// - a 32-bit snapshot holds both counts and is read as four separate bytes.
module dcb_dual_counter #(
    parameter int CNT_W = `DCB_CNT_W
) (
    // system clock and reset
    input wire logic clock,
    input wire logic rstn,
    // count side pins
    input wire logic count_clock_first,
    input wire logic count_clock_second,
    input wire logic second_count_enable_n,
    input wire logic shared_counter_clear_n,
    output logic first_terminal_count_n,
    // readout side pins
    input wire logic register_clock,
    input wire dcb_pkg::dcb_gates_s gates_n,
    output logic [`DCB_BYTE_W-1:0] byte_out,
    output logic [`DCB_BYTE_W-1:0] byte_oe
);
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // clear joins the reset tree so it acts with no clock edge at all
    logic clr_meta_r;
    logic clr_sync_r;
    wire cnt_rst_n = rst_sync_r & shared_counter_clear_n;
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            clr_meta_r <= 1'b0;
            clr_sync_r <= 1'b0;
        end else begin
            clr_meta_r <= shared_counter_clear_n;
            clr_sync_r <= clr_meta_r;
        end
    end

    logic first_rise;
    logic second_rise;
    logic reg_rise;
    logic en_meta_r;
    logic en_sync_n_r;
    dcb_edge_sync u_sync_first (
        .clock(clock),
        .rst_n(rst_sync_r),
        .pin(count_clock_first),
        .level(),
        .rise(first_rise)
    );
    dcb_edge_sync u_sync_second (
        .clock(clock),
        .rst_n(rst_sync_r),
        .pin(count_clock_second),
        .level(),
        .rise(second_rise)
    );
    dcb_edge_sync u_sync_reg (
        .clock(clock),
        .rst_n(rst_sync_r),
        .pin(register_clock),
        .level(),
        .rise(reg_rise)
    );
    // enable synchronised with the same latency as the edge, so it is sampled at that edge
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            en_meta_r <= 1'b1;
            en_sync_n_r <= 1'b1;
        end else begin
            en_meta_r <= second_count_enable_n;
            en_sync_n_r <= en_meta_r;
        end
    end

    // counters; edges seen while clear is still settling are dropped
    logic [CNT_W-1:0] first_r;
    logic [CNT_W-1:0] second_r;
    wire count_ok = clr_sync_r;
    wire [CNT_W-1:0] first_nxt = first_r + {{(CNT_W-1){1'b0}}, 1'b1};
    wire [CNT_W-1:0] second_nxt = second_r + {{(CNT_W-1){1'b0}}, 1'b1};
    wire second_step = second_rise & ~en_sync_n_r & count_ok;
    always_ff @(posedge clock or negedge cnt_rst_n) begin
        if (!cnt_rst_n) begin
            first_r <= CNT_W'(`DCB_CNT_RST);
            second_r <= CNT_W'(`DCB_CNT_RST);
        end else begin
            if (first_rise && count_ok) begin
                first_r <= first_nxt;
            end
            if (second_step) begin
                second_r <= second_nxt;
            end
        end
    end

    wire first_full = &first_r;
    always_ff @(posedge clock or negedge cnt_rst_n) begin
        if (!cnt_rst_n) begin
            first_terminal_count_n <= 1'b1;
        end else begin
            first_terminal_count_n <= ~(first_rise && count_ok ? &first_nxt : first_full);
        end
    end

    // narrower counters are zero-extended into the fixed 16-bit snapshot fields
    dcb_pkg::dcb_count_t first_wide;
    dcb_pkg::dcb_count_t second_wide;
    assign first_wide = dcb_pkg::dcb_count_t'(first_r);
    assign second_wide = dcb_pkg::dcb_count_t'(second_r);

    // snapshot is not cleared by the shared clear, only by system reset
    dcb_pkg::dcb_snap_s snap_r;
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            snap_r <= '0;
        end else if (reg_rise) begin
            snap_r <= {second_wide, first_wide};
        end
    end

    logic [3:0] gate_meta_r;
    logic [3:0] gate_sync_n_r;
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            gate_meta_r <= 4'hF;
            gate_sync_n_r <= 4'hF;
        end else begin
            gate_meta_r <= gates_n;
            gate_sync_n_r <= gate_meta_r;
        end
    end

    // if several gates are low the first-listed wins; the host must not do that
    wire sel_a_lo = ~gate_sync_n_r[3];
    wire sel_a_hi = ~gate_sync_n_r[2];
    wire sel_b_lo = ~gate_sync_n_r[1];
    wire sel_b_hi = ~gate_sync_n_r[0];
    wire any_sel = sel_a_lo | sel_a_hi | sel_b_lo | sel_b_hi;
    wire [`DCB_BYTE_W-1:0] byte_sel =
        sel_a_lo ? snap_r.first[`DCB_BYTE_LO +: `DCB_BYTE_W] :
        sel_a_hi ? snap_r.first[`DCB_BYTE_HI +: `DCB_BYTE_W] :
        sel_b_lo ? snap_r.second[`DCB_BYTE_LO +: `DCB_BYTE_W] :
        sel_b_hi ? snap_r.second[`DCB_BYTE_HI +: `DCB_BYTE_W] :
        `DCB_BYTE_W'(0);
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            byte_out <= '0;
            byte_oe <= '0;
        end else begin
            byte_out <= byte_sel;
            byte_oe <= {`DCB_BYTE_W{any_sel}};
        end
    end
endmodule

// ===== sim/dcb_dual_counter_properties.sv
`timescale 1ns/1ns
module dcb_checker (
    // clock
    input wire logic clock,
    input wire logic rstn,
    // pins
    input wire logic count_clock_first,
    input wire logic shared_counter_clear_n,
    input wire logic first_terminal_count_n,
    input wire logic register_clock,
    input wire dcb_pkg::dcb_gates_s gates_n,
    input wire logic [7:0] byte_out,
    input wire logic [7:0] byte_oe
);
    logic [3:0] up_r;
    wire up = up_r[3];
    wire idle = &gates_n;
    wire tc = first_terminal_count_n;
    wire clr_n = shared_counter_clear_n;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // skips the internal reset copy and the input pipes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) up_r <= 4'h0;
        else if (!up) up_r <= up_r + 4'h1;
    end
    property p_rel; (up && idle)[*3] |=> byte_oe == 8'h00; endproperty
    a_rel: assert property (p_rel) else $error("bus held");
    property p_drv; (up && !idle)[*3] |=> byte_oe == 8'hff; endproperty
    a_drv: assert property (p_drv) else $error("bus idle");
    property p_cause; byte_oe == 8'hff |-> !(&$past(gates_n, 3)); endproperty
    a_cause: assert property (p_cause) else $error("bus no gate");
    property p_same; byte_oe == 8'h00 || byte_oe == 8'hff; endproperty
    a_same: assert property (p_same) else $error("bus split");
    property p_clr; !clr_n |-> tc; endproperty
    a_clr: assert property (p_clr) else $error("tc in clear");
    property p_tc; (up && clr_n && $stable(count_clock_first))[*6] |=> !clr_n || $stable(tc);
    endproperty
    a_tc: assert property (p_tc) else $error("tc moved");
    property p_fell; $fell(tc) |-> $past(count_clock_first, 2) || $past(count_clock_first, 3);
    endproperty
    a_fell: assert property (p_fell) else $error("tc no edge");
    property p_out; (up && $stable(gates_n) && $stable(register_clock))[*6] |=> $stable(byte_out);
    endproperty
    a_out: assert property (p_out) else $error("byte moved");
endmodule
bind dcb_dual_counter dcb_checker u_chk (.clock(clock), .rstn(rstn),
    .count_clock_first(count_clock_first), .shared_counter_clear_n(shared_counter_clear_n),
    .first_terminal_count_n(first_terminal_count_n), .register_clock(register_clock),
    .gates_n(gates_n), .byte_out(byte_out), .byte_oe(byte_oe));

// ===== sim/dcb_host_model.sv
`timescale 1ns/1ns
module dcb_host_model (
    // clock
    input wire logic clock,
    // bus
    input wire logic [7:0] byte_out,
    input wire logic [7:0] byte_oe,
    output dcb_pkg::dcb_gates_s gates_n,
    output logic register_clock
);
    initial begin
        gates_n = 4'hf;
        register_clock = 1'b0;
    end
    // a released bus reads back inverted so it never passes by luck
    task automatic read_all(output logic [31:0] v, output logic [7:0] z);
        register_clock = 1'b1;
        repeat (2) @(posedge clock);
        #1 register_clock = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        for (int i = 3; i >= 0; i--) begin
            gates_n = ~(4'h1 << i);
            repeat (4) @(posedge clock);
            // sample off the edge so the value is settled
            #1 v[(3-i)*8 +: 8] = (byte_oe == 8'hff) ? byte_out : ~byte_out;
            gates_n = 4'hf;
            repeat (4) @(posedge clock);
            #1;
        end
        z = byte_oe;
    endtask
endmodule

// ===== sim/dual_counter_byte_readout_tb_top.sv
`timescale 1ns/1ns
module dual_counter_byte_readout_tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic ca = 1'b0;
    logic cb = 1'b0;
    logic en_n = 1'b1;
    logic clr_n = 1'b1;
    logic chain = 1'b0;
    logic tc_n, rclk;
    logic [7:0] bo, oe;
    dcb_pkg::dcb_gates_s g_n;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    wire en_pin = chain ? tc_n : en_n;
    always #20 clock = ~clock;
    dcb_dual_counter #(.CNT_W(8)) dut (.clock(clock), .rstn(rstn), .count_clock_first(ca),
        .count_clock_second(cb), .second_count_enable_n(en_pin), .shared_counter_clear_n(clr_n),
        .first_terminal_count_n(tc_n), .register_clock(rclk), .gates_n(g_n), .byte_out(bo),
        .byte_oe(oe));
    dcb_host_model host (.clock(clock), .byte_out(bo), .byte_oe(oe), .gates_n(g_n),
        .register_clock(rclk));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
        num_checks++;
        if (v !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic pulse(input logic a, input logic b, input int n);
        repeat (n) begin
            ca = a;
            cb = b;
            tick(2);
            ca = 1'b0;
            cb = 1'b0;
            tick(2);
        end
    endtask
    task automatic rd(input logic [31:0] e);
        logic [31:0] v;
        logic [7:0] z;
        host.read_all(v, z);
        chk("snapshot", e, v);
        chk("idle oe", 32'h0000_0000, {24'h00_0000, z});
    endtask
    task automatic t_basic();
        pulse(1'b1, 1'b0, 3);
        en_n = 1'b0;
        pulse(1'b0, 1'b1, 5);
        en_n = 1'b1;
        pulse(1'b1, 1'b1, 4);
        rd(32'h0005_0007);
        $display("basic done");
    endtask
    task automatic t_chain();
        chain = 1'b1;
        pulse(1'b1, 1'b1, 248);
        chk("tc", 32'h0000_0000, {31'h0000_0000, tc_n});
        pulse(1'b1, 1'b1, 1);
        chk("tc", 32'h0000_0001, {31'h0000_0000, tc_n});
        chain = 1'b0;
        rd(32'h0006_0000);
        $display("chain done");
    endtask
    task automatic t_clear();
        pulse(1'b1, 1'b0, 255);
        clr_n = 1'b0;
        #1 chk("tc", 32'h0000_0001, {31'h0000_0000, tc_n});
        tick(2);
        clr_n = 1'b1;
        tick(4);
        rd(32'h0000_0000);
        $display("clear done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        tick(2);
        rstn = 1'b1;
        tick(6);
        t_basic();
        t_chain();
        t_clear();
        test_done();
    end
endmodule
